//--- pkg/cadsp_if.sv
// Serial link between the converter port and its host controller.
`timescale 1ns/100ps
interface cadsp_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic dout_oe;
  logic dout_line;
  logic chain_input;
  logic chain_output;
  logic ready_chain_in;
  logic ready_chain_out;

  // Released data line reads high through a pull-up.
  assign dout_line = dout_oe ? dout : 1'b1;

  modport dev (
    input  cs_n, sclk, din, chain_input, ready_chain_in,
    output dout, dout_oe, chain_output, ready_chain_out
  );

  modport host (
    input  dout_line, chain_output, ready_chain_out,
    output cs_n, sclk, din, chain_input, ready_chain_in
  );
endinterface : cadsp_if

//--- pkg/cadsp_pkg.sv
// Shared constants and helpers of the cascadable converter serial port.
package cadsp_pkg;

  // Command byte layout.
  localparam int          CMD_W         = 8;
  localparam int          CMD_RW_BIT    = 7;
  localparam int          ADDR_W        = 7;
  localparam logic        RW_WRITE      = 1'b0;
  localparam logic        RW_READ       = 1'b1;

  // Register addresses.
  localparam logic [6:0]  ADDR_SDELAY   = 7'h40;
  localparam logic [6:0]  ADDR_RATE     = 7'h50;
  localparam logic [6:0]  ADDR_CONFIG   = 7'h60;
  localparam logic [6:0]  ADDR_RESULT   = 7'h70;

  // Register widths per device.
  localparam int          SDELAY_W      = 32;
  localparam int          RATE_W        = 16;
  localparam int          CONFIG_W      = 8;
  localparam int          RESULT_W      = 96;
  localparam int          MAX_DEV       = 8;

  // Reset values.
  localparam logic [31:0] SDELAY_RESET  = 32'h0000_0000;
  localparam logic [15:0] RATE_RESET    = 16'h0000;
  localparam logic [7:0]  CONFIG_RESET  = 8'h00;

  // Configuration fields.
  localparam int          CFG_SOFT_RST  = 6;
  localparam logic [7:0]  CFG_KEEP_MASK = 8'hBC;

  // Sample delay fields.
  localparam int          DLY_FIELD_W   = 8;
  localparam int          DLY_STEP_LOG2 = 5;
  localparam int          DLY_CYC_W     = DLY_FIELD_W + DLY_STEP_LOG2;
  localparam int          NUM_CH        = 4;

  // Link timing.
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          SCLK_PERIOD_NS = 80;
  localparam int          SCLK_HALF_CYC  = SCLK_PERIOD_NS / CLK_PERIOD_NS / 2;

  // Data bits that follow a command byte for a chain of n devices.
  function automatic logic [15:0] data_len(input logic rw, input logic [6:0] addr, input int n);
    logic [15:0] nn;
    nn = 16'(n);
    unique case (addr)
      ADDR_SDELAY: data_len = 16'(SDELAY_W) * nn;
      ADDR_RATE:   data_len = 16'(RATE_W);
      ADDR_CONFIG: data_len = 16'(CONFIG_W) * nn;
      ADDR_RESULT: data_len = (rw == RW_READ) ? 16'(RESULT_W) * nn : 16'h0000;
      default:     data_len = 16'h0000;
    endcase
  endfunction : data_len

endpackage : cadsp_pkg

//--- verification/cadsp_link_asserts.sv
// Checker that watches the serial link between the host and converter ends.
`timescale 1ns/100ps
module cadsp_link_asserts (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic chain_input,
  input wire logic ready_chain_in,
  input wire logic ready_chain_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Counts serial clock falls within the current frame.
  logic       sclk_d_ff;
  logic       nxt_sclk_d;
  logic [7:0] falls_ff;
  logic [7:0] nxt_falls;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic [7:0] exp_falls;
  always_comb begin
    nxt_sclk_d = sclk;
    nxt_falls  = cs_n ? 8'h00 : falls_ff + 8'(sclk_d_ff & ~sclk);
    nxt_cmd    = (!cs_n && sclk_d_ff && !sclk && falls_ff < 8'h08) ? {cmd_ff[6:0], din} : cmd_ff;
    case (cmd_ff)
      8'h40, 8'hC0: exp_falls = 8'h28;
      8'h50, 8'hD0: exp_falls = 8'h18;
      8'h60, 8'hE0: exp_falls = 8'h10;
      8'hF0:        exp_falls = 8'h68;
      default:      exp_falls = 8'h08;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclk_d_ff <= 1'b1;
      falls_ff  <= 8'h00;
      cmd_ff    <= 8'h00;
    end else begin
      sclk_d_ff <= nxt_sclk_d;
      falls_ff  <= nxt_falls;
      cmd_ff    <= nxt_cmd;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_sclk_idle;
    cs_n |-> sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock low outside frame");
  property p_sclk_framed;
    $changed(sclk) |-> !cs_n;
  endproperty
  a_sclk_framed: assert property (p_sclk_framed) else $error("clock moved without select");
  property p_din_hold;
    !cs_n && !sclk |-> $stable(din);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("input moved while clock low");
  property p_dout_hold;
    !cs_n && !sclk |-> $stable(dout);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("output moved while clock low");
  property p_release;
    (cs_n || chain_input) [*5] |-> !dout_oe;
  endproperty
  a_release: assert property (p_release) else $error("output driven while deselected");
  property p_frame_len;
    $rose(cs_n) |-> falls_ff == exp_falls;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
  property p_cs_gap;
    $rose(cs_n) |=> cs_n [*8];
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("frames too close");
  property p_ready_fall;
    $fell(ready_chain_out) |-> !$past(ready_chain_in, 3);
  endproperty
  a_ready_fall: assert property (p_ready_fall) else $error("ready fell while chain ready high");
  c_result_read: cover property ($rose(cs_n) && falls_ff == 8'h68);
  c_delay_frame: cover property ($rose(cs_n) && falls_ff == 8'h28);
  c_ready: cover property ($fell(ready_chain_out));
endmodule : cadsp_link_asserts

//--- verification/tb_top.sv
// Testbench joining host and converter ends over the serial link.
`timescale 1ns/100ps
module tb_top;
  logic         clk_sys = 1'b0;
  logic         nrst = 1'b0;
  logic         cmd_valid = 1'b0;
  logic         cmd_write = 1'b0;
  logic [6:0]   cmd_addr = 7'h00;
  logic [95:0]  cmd_wdata = 96'h0;
  logic [95:0]  result_data = 96'h0;
  logic         result_valid = 1'b0;
  logic         cmd_ready, rsp_valid, results_ready;
  logic [95:0]  rsp_rdata;
  logic [12:0]  dl0, dl1, dl2, dl3;
  logic [15:0]  rate_setting;
  logic [7:0]   config_setting, cfg_b;
  logic [127:0] din_sr, dout_sr;
  int           failures = 0;
  int           samples_checked = 0;
  cadsp_if link_a();
  cadsp_if link_b();
  always #2 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  cadsp_host cadsp_host_i (.clk_sys(clk_sys), .nrst(nrst), .link(link_a), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .results_ready(results_ready));
  cadsp_dev cadsp_dev_i (.clk_sys(clk_sys), .nrst(nrst), .link(link_a), .result_valid(result_valid),
    .result_data(result_data), .ch0_sample_delay(dl0), .ch1_sample_delay(dl1), .ch2_sample_delay(dl2),
    .ch3_sample_delay(dl3), .rate_setting(rate_setting), .config_setting(config_setting));
  cadsp_dev cadsp_dev_b_i (.clk_sys(clk_sys), .nrst(nrst), .link(link_b), .result_valid(1'b0),
    .result_data(96'h0), .ch0_sample_delay(), .ch1_sample_delay(), .ch2_sample_delay(),
    .ch3_sample_delay(), .rate_setting(), .config_setting(cfg_b));
  cadsp_link_asserts cadsp_link_asserts_i (.clk_sys(clk_sys), .nrst(nrst), .cs_n(link_a.cs_n),
    .sclk(link_a.sclk), .din(link_a.din), .dout(link_a.dout), .dout_oe(link_a.dout_oe),
    .chain_input(link_a.chain_input), .ready_chain_in(link_a.ready_chain_in),
    .ready_chain_out(link_a.ready_chain_out));
  // Captures both data lines at each falling link clock edge.
  always @(negedge link_a.sclk) begin
    din_sr  <= {din_sr[126:0], link_a.din};
    dout_sr <= {dout_sr[126:0], link_a.dout_line};
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [127:0] ex, input logic [127:0] got);
    samples_checked++;
    if (got !== ex) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic op(input logic wr, input logic [6:0] a, input logic [95:0] wd);
    int n;
    cmd_write <= wr;
    cmd_addr  <= a;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'b1 && n < 4000);
    if (n >= 4000) chk("rsp_valid", 1, 0);
  endtask : op
  // Drives the second link by hand, taking n bits of v from the top.
  task automatic bb(input logic [15:0] v, input int n);
    link_b.cs_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      link_b.din <= v[i];
      repeat (10) @(posedge clk_sys);
      link_b.sclk <= 1'b0;
      repeat (10) @(posedge clk_sys);
      link_b.sclk <= 1'b1;
    end
    repeat (10) @(posedge clk_sys);
    link_b.cs_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
  endtask : bb
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    op(1'b0, 7'h40, 96'h0);
    chk("delay reg", 0, rsp_rdata);
    op(1'b0, 7'h50, 96'h0);
    chk("rate reg", 0, rsp_rdata);
    op(1'b0, 7'h60, 96'h0);
    chk("config reg", 0, rsp_rdata);
    chk("ch3 delay", 0, dl3);
  endtask : t_reset
  task automatic t_regs();
    op(1'b1, 7'h40, 96'h1A2B3C4D);
    chk("din order", {8'h40, 32'h1A2B3C4D}, din_sr[39:0]);
    chk("ch delays", {8'h1A, 5'h0, 8'h2B, 5'h0, 8'h3C, 5'h0, 8'h4D, 5'h0}, {dl0, dl1, dl2, dl3});
    op(1'b0, 7'h40, 96'h0);
    chk("delay read", 32'h1A2B3C4D, rsp_rdata);
    chk("dout order", 32'h1A2B3C4D, dout_sr[31:0]);
    op(1'b1, 7'h50, 96'hBEEF);
    op(1'b0, 7'h50, 96'h0);
    chk("rate read", {16'hBEEF, 16'hBEEF}, {rsp_rdata[15:0], rate_setting});
    op(1'b1, 7'h60, 96'hA7);
    op(1'b0, 7'h60, 96'h0);
    chk("config read", {8'hA4, 8'hA4}, {rsp_rdata[7:0], config_setting});
    op(1'b1, 7'h60, 96'h40);
    chk("soft reset", 0, {dl0, rate_setting, config_setting});
  endtask : t_regs
  task automatic t_result();
    result_data  <= 96'h800001FF_FFFE7FFF_01234567;
    result_valid <= 1'b1;
    @(posedge clk_sys);
    result_data  <= 96'h7FFFFE00_0001C000_89ABCDEF;
    repeat (8) @(posedge clk_sys);
    result_valid <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("results ready", 1, results_ready);
    op(1'b0, 7'h70, 96'h0);
    chk("result read", 96'h7FFFFE00_0001C000_89ABCDEF, rsp_rdata);
    chk("ready cleared", 0, results_ready);
    op(1'b1, 7'h70, 96'h5);
    op(1'b0, 7'h70, 96'h0);
    chk("result kept", 96'h7FFFFE00_0001C000_89ABCDEF, rsp_rdata);
    op(1'b0, 7'h30, 96'h0);
    chk("unmapped read", 0, rsp_rdata);
  endtask : t_result
  task automatic t_abort();
    bb({8'h60, 8'h84}, 12);
    chk("cut write", 0, cfg_b);
    chk("released", 0, link_b.dout_oe);
    bb({8'h60, 8'h84}, 16);
    chk("full write", 8'h84, cfg_b);
    link_b.chain_input <= 1'b1;
    bb({8'h60, 8'h80}, 16);
    chk("skipped write", 8'h84, cfg_b);
  endtask : t_abort
  task automatic give_verdict();
    if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    link_b.cs_n = 1'b1;
    link_b.sclk = 1'b1;
    link_b.din = 1'b0;
    link_b.chain_input = 1'b0;
    link_b.ready_chain_in = 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_result();
    t_abort();
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end
endmodule : tb_top

//--- verilog/cadsp_dev.sv
// Converter end: serial register port with four registers.
`timescale 1ns/100ps
// What this block does
// RL1 - Clock idles high, data phase zero.
// RL2 - Four registers: 32, 16, 8, 96 bits.
// RL3 - Command byte first, then register data.
// RL4 - Single device: host grounds chain inputs.
// RL5 - Ready output falls on new results.
// RL6 - Input bit sampled on clock fall.
// RL7 - Output changes on clock rise.
// RL8 - All words shifted most significant first.
// RL9 - Chip select high: ignore, release output.
// RL10 - Transfer takes effect at last rise.
// RL11 - Early chip select rise discards write.
// RL12 - Command holds direction bit and address.
// RL13 - Delay, rate, configuration codes read/write.
// RL14 - Result register read only.
// RL15 - Data length scales with device count.
// RL16 - Rate access always 16 bits, shared.
// RL17 - Channel delays reset to zero.
// RL18 - Delay is 32 input clocks per count.
// RL19 - Channel fields at 31:24, 23:16, 15:8, 7:0.
// RL20 - Configuration resets to all zeros.
// RL21 - Eight configuration bits per device.
// RL22 - Results delivered as two's complement.
// RL23 - New result overwrites unread result.
// RL24 - Direction bit is the byte's top.
module cadsp_dev (
  input  wire logic                                     clk_sys,
  input  wire logic                                     nrst,
  cadsp_if.dev                                          link,
  input  wire logic                                     result_valid,
  input  wire logic [cadsp_pkg::RESULT_W-1:0]           result_data,
  output logic      [cadsp_pkg::DLY_CYC_W-1:0]          ch0_sample_delay,
  output logic      [cadsp_pkg::DLY_CYC_W-1:0]          ch1_sample_delay,
  output logic      [cadsp_pkg::DLY_CYC_W-1:0]          ch2_sample_delay,
  output logic      [cadsp_pkg::DLY_CYC_W-1:0]          ch3_sample_delay,
  output logic      [cadsp_pkg::RATE_W-1:0]             rate_setting,
  output logic      [cadsp_pkg::CONFIG_W-1:0]           config_setting
);
  localparam int RW = cadsp_pkg::RESULT_W;
  localparam int CW = cadsp_pkg::CMD_W;

  logic [3:0]                    pins_s;
  logic                          cs_n_s;
  logic                          sclk_s;
  logic                          din_s;
  logic                          chain_in_s;
  logic                          rdy_in_s;
  logic                          sclk_d_ff;
  logic                          fall;
  logic                          rise;
  logic                          active;
  logic [7:0]                    bit_ff, nxt_bit;
  logic [CW-1:0]                 cmd_ff, nxt_cmd;
  logic [RW-1:0]                 rx_ff, nxt_rx;
  logic [RW-1:0]                 tx_ff, nxt_tx;
  logic                          dout_ff, nxt_dout;
  logic                          pend_ff, nxt_pend;
  logic                          done_ff, nxt_done;
  logic                          rdy_out_ff, nxt_rdy_out;
  logic [cadsp_pkg::SDELAY_W-1:0] sdelay_ff, nxt_sdelay; // [RL2]
  logic [cadsp_pkg::RATE_W-1:0]   rate_ff, nxt_rate;
  logic [cadsp_pkg::CONFIG_W-1:0] config_ff, nxt_config;
  logic [RW-1:0]                 result_ff, nxt_result;
  logic [15:0]                   len;
  logic                          is_read;
  logic [7:0]                    frame_end;
  logic [CW-1:0]                 cmd_now;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and clock edge detection.
  cadsp_sync #(.W(4), .RESET_VAL(32'h0000_000C)) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .pin_in   ({link.cs_n, link.sclk, link.din, link.ready_chain_in}),
    .pin_sync (pins_s)
  );

  cadsp_sync #(.W(1), .RESET_VAL(32'h0000_0000)) u_sync_chain (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .pin_in   (link.chain_input),
    .pin_sync (chain_in_s)
  );

  assign cs_n_s   = pins_s[3];
  assign sclk_s   = pins_s[2];
  assign din_s    = pins_s[1];
  assign rdy_in_s = pins_s[0];

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sclk_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  assign active = ~cs_n_s & ~chain_in_s; // [RL9]
  assign fall   = active & sclk_d_ff & ~sclk_s; // [RL1] [RL6]
  assign rise   = active & ~sclk_d_ff & sclk_s; // [RL1] [RL7]

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  assign is_read   = cmd_ff[cadsp_pkg::CMD_RW_BIT] == cadsp_pkg::RW_READ; // [RL12] [RL24]
  assign len       = cadsp_pkg::data_len(is_read, cmd_ff[cadsp_pkg::ADDR_W-1:0], 1); // [RL15] [RL16] [RL21]
  assign frame_end = 8'(len) + 8'(CW);
  assign cmd_now   = {rx_ff[CW-2:0], din_s};

  ////////////////////////////////////////////////////////////////////////////
  // Shift engine and registers.
  always_comb begin
    nxt_bit     = bit_ff;
    nxt_cmd     = cmd_ff;
    nxt_rx      = rx_ff;
    nxt_tx      = tx_ff;
    nxt_dout    = dout_ff;
    nxt_pend    = pend_ff;
    nxt_done    = done_ff;
    nxt_rdy_out = rdy_out_ff;
    nxt_sdelay  = sdelay_ff;
    nxt_rate    = rate_ff;
    nxt_config  = config_ff;
    nxt_result  = result_ff;
    if (!active) begin
      nxt_bit  = 8'h00; // [RL9]
      nxt_pend = 1'b0; // [RL11]
      nxt_done = 1'b0;
    end else if (fall) begin
      nxt_rx  = {rx_ff[RW-2:0], din_s}; // [RL6] [RL8]
      nxt_bit = bit_ff + 8'h01;
      if (bit_ff == 8'(CW - 1)) begin
        nxt_cmd = cmd_now; // [RL3]
      end
      if (bit_ff >= 8'(CW) && !is_read && len != 16'h0000 && bit_ff + 8'h01 == frame_end) begin
        nxt_pend = 1'b1; // [RL10]
      end
      if (bit_ff >= 8'(CW) && bit_ff + 8'h01 == frame_end) begin
        nxt_done = 1'b1;
      end
    end else if (rise) begin
      if (bit_ff == 8'(CW) && is_read) begin
        unique case (cmd_ff[cadsp_pkg::ADDR_W-1:0])
          cadsp_pkg::ADDR_SDELAY: nxt_tx = {sdelay_ff, 64'h0}; // [RL13]
          cadsp_pkg::ADDR_RATE:   nxt_tx = {rate_ff, 80'h0}; // [RL13] [RL16]
          cadsp_pkg::ADDR_CONFIG: nxt_tx = {config_ff, 88'h0}; // [RL13] [RL21]
          cadsp_pkg::ADDR_RESULT: nxt_tx = result_ff; // [RL14] [RL22]
          default:                nxt_tx = '0;
        endcase
        nxt_dout = nxt_tx[RW-1]; // [RL7] [RL8]
        nxt_tx   = nxt_tx << 1;
        if (cmd_ff[cadsp_pkg::ADDR_W-1:0] == cadsp_pkg::ADDR_RESULT) begin
          nxt_rdy_out = 1'b1;
        end
      end else if (bit_ff > 8'(CW) && is_read && bit_ff < frame_end) begin
        nxt_dout = tx_ff[RW-1]; // [RL7]
        nxt_tx   = tx_ff << 1;
      end
      if (pend_ff) begin
        nxt_pend = 1'b0; // [RL10]
        unique case (cmd_ff[cadsp_pkg::ADDR_W-1:0])
          cadsp_pkg::ADDR_SDELAY: nxt_sdelay = rx_ff[cadsp_pkg::SDELAY_W-1:0]; // [RL13]
          cadsp_pkg::ADDR_RATE:   nxt_rate   = rx_ff[cadsp_pkg::RATE_W-1:0]; // [RL16]
          cadsp_pkg::ADDR_CONFIG: begin
            if (rx_ff[cadsp_pkg::CFG_SOFT_RST]) begin
              nxt_sdelay = cadsp_pkg::SDELAY_RESET;
              nxt_rate   = cadsp_pkg::RATE_RESET;
              nxt_config = cadsp_pkg::CONFIG_RESET;
            end else begin
              nxt_config = rx_ff[cadsp_pkg::CONFIG_W-1:0] & cadsp_pkg::CFG_KEEP_MASK; // [RL20]
            end
          end
          default: nxt_pend = 1'b0; // [RL14]
        endcase
      end
    end
    if (result_valid) begin
      nxt_result = result_data; // [RL23]
      if (!rdy_in_s) begin
        nxt_rdy_out = 1'b0; // [RL5]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bit_ff     <= 8'h00;
      cmd_ff     <= 8'h00;
      rx_ff      <= '0;
      tx_ff      <= '0;
      dout_ff    <= 1'b0;
      pend_ff    <= 1'b0;
      done_ff    <= 1'b0;
      rdy_out_ff <= 1'b1;
      sdelay_ff  <= cadsp_pkg::SDELAY_RESET; // [RL17]
      rate_ff    <= cadsp_pkg::RATE_RESET;
      config_ff  <= cadsp_pkg::CONFIG_RESET; // [RL20]
      result_ff  <= '0;
    end else begin
      bit_ff     <= nxt_bit;
      cmd_ff     <= nxt_cmd;
      rx_ff      <= nxt_rx;
      tx_ff      <= nxt_tx;
      dout_ff    <= nxt_dout;
      pend_ff    <= nxt_pend;
      done_ff    <= nxt_done;
      rdy_out_ff <= nxt_rdy_out;
      sdelay_ff  <= nxt_sdelay;
      rate_ff    <= nxt_rate;
      config_ff  <= nxt_config;
      result_ff  <= nxt_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  genvar g;
  logic [cadsp_pkg::DLY_CYC_W-1:0] dly_cyc [cadsp_pkg::NUM_CH];
  generate
    for (g = 0; g < cadsp_pkg::NUM_CH; g++) begin : g_dly
      localparam int HI = cadsp_pkg::SDELAY_W - 1 - g * cadsp_pkg::DLY_FIELD_W;
      assign dly_cyc[g] = {sdelay_ff[HI -: cadsp_pkg::DLY_FIELD_W],
                           {cadsp_pkg::DLY_STEP_LOG2{1'b0}}}; // [RL18] [RL19]
    end
  endgenerate

  assign ch0_sample_delay     = dly_cyc[0];
  assign ch1_sample_delay     = dly_cyc[1];
  assign ch2_sample_delay     = dly_cyc[2];
  assign ch3_sample_delay     = dly_cyc[3];
  assign rate_setting         = rate_ff;
  assign config_setting       = config_ff;
  assign link.dout            = dout_ff;
  assign link.dout_oe         = active; // [RL9]
  assign link.chain_output    = done_ff;
  assign link.ready_chain_out = rdy_out_ff; // [RL5]
endmodule : cadsp_dev

//--- verilog/cadsp_host.sv
// Host controller end: runs frames on the serial link on request.
`timescale 1ns/100ps
module cadsp_host #(
  parameter int N_DEV    = 1,
  parameter int HALF_CYC = cadsp_pkg::SCLK_HALF_CYC,
  parameter int MAXLEN   = cadsp_pkg::RESULT_W * N_DEV
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  cadsp_if.host                  link,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [6:0]        cmd_addr,
  input  wire logic [MAXLEN-1:0] cmd_wdata,
  output logic                   cmd_ready,
  output logic                   rsp_valid,
  output logic      [MAXLEN-1:0] rsp_rdata,
  output logic                   results_ready
);
  localparam int FW = MAXLEN + cadsp_pkg::CMD_W;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_TAIL = 2'b10,
    ST_GAP  = 2'b11
  } cadsp_hst_t;

  cadsp_hst_t        st_ff, nxt_st;
  logic [7:0]        half_ff, nxt_half;
  logic [15:0]       bit_ff, nxt_bit;
  logic [15:0]       total_ff, nxt_total;
  logic [FW-1:0]     tx_ff, nxt_tx;
  logic [MAXLEN-1:0] rx_ff, nxt_rx;
  logic              cs_n_ff, nxt_cs_n;
  logic              sclk_ff, nxt_sclk;
  logic              din_ff, nxt_din;
  logic              rsp_ff, nxt_rsp;
  logic [1:0]        pins_s;
  logic [15:0]       len;
  logic              tick;

  cadsp_sync #(.W(2), .RESET_VAL(32'h0000_0003)) u_sync (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .pin_in   ({link.dout_line, link.ready_chain_out}),
    .pin_sync (pins_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer.
  assign len  = cadsp_pkg::data_len(~cmd_write, cmd_addr, N_DEV);
  assign tick = (half_ff == 8'(HALF_CYC - 1));

  always_comb begin
    nxt_st    = st_ff;
    nxt_half  = half_ff;
    nxt_bit   = bit_ff;
    nxt_total = total_ff;
    nxt_tx    = tx_ff;
    nxt_rx    = rx_ff;
    nxt_cs_n  = cs_n_ff;
    nxt_sclk  = sclk_ff;
    nxt_din   = din_ff;
    nxt_rsp   = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        if (cmd_valid) begin
          nxt_tx    = {cmd_write ? cadsp_pkg::RW_WRITE : cadsp_pkg::RW_READ, cmd_addr,
                       cmd_wdata << (16'(MAXLEN) - len)}; // [RL3] [RL12] [RL24] [RL15]
          nxt_din   = nxt_tx[FW-1]; // [RL8]
          nxt_total = len + 16'(cadsp_pkg::CMD_W);
          nxt_bit   = 16'h0000;
          nxt_half  = 8'h00;
          nxt_rx    = '0;
          nxt_cs_n  = 1'b0; // [RL4]
          nxt_st    = ST_RUN;
        end
      end
      ST_RUN: begin
        nxt_half = tick ? 8'h00 : half_ff + 8'h01;
        if (tick && sclk_ff) begin
          nxt_sclk = 1'b0; // [RL1] [RL6]
          if (bit_ff >= 16'(cadsp_pkg::CMD_W)) begin
            nxt_rx = {rx_ff[MAXLEN-2:0], pins_s[1]}; // [RL7]
          end
        end else if (tick) begin
          nxt_sclk = 1'b1;
          if (bit_ff == total_ff - 16'h0001) begin
            nxt_st = ST_TAIL;
          end else begin
            nxt_bit = bit_ff + 16'h0001;
            nxt_tx  = tx_ff << 1;
            nxt_din = tx_ff[FW-2];
          end
        end
      end
      ST_TAIL: begin
        nxt_half = tick ? 8'h00 : half_ff + 8'h01;
        if (tick) begin
          nxt_cs_n = 1'b1;
          nxt_rsp  = 1'b1;
          nxt_st   = ST_GAP;
        end
      end
      ST_GAP: begin
        nxt_half = tick ? 8'h00 : half_ff + 8'h01;
        if (tick) begin
          nxt_st = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_ff    <= ST_IDLE;
      half_ff  <= 8'h00;
      bit_ff   <= 16'h0000;
      total_ff <= 16'h0000;
      tx_ff    <= '0;
      rx_ff    <= '0;
      cs_n_ff  <= 1'b1;
      sclk_ff  <= 1'b1;
      din_ff   <= 1'b0;
      rsp_ff   <= 1'b0;
    end else begin
      st_ff    <= nxt_st;
      half_ff  <= nxt_half;
      bit_ff   <= nxt_bit;
      total_ff <= nxt_total;
      tx_ff    <= nxt_tx;
      rx_ff    <= nxt_rx;
      cs_n_ff  <= nxt_cs_n;
      sclk_ff  <= nxt_sclk;
      din_ff   <= nxt_din;
      rsp_ff   <= nxt_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and user side.
  assign link.cs_n           = cs_n_ff;
  assign link.sclk           = sclk_ff;
  assign link.din            = din_ff;
  assign link.chain_input    = 1'b0; // [RL4]
  assign link.ready_chain_in = 1'b0; // [RL4]
  assign cmd_ready           = (st_ff == ST_IDLE);
  assign rsp_valid           = rsp_ff;
  assign rsp_rdata           = rx_ff;
  assign results_ready       = ~pins_s[0];
endmodule : cadsp_host

//--- verilog/cadsp_sync.sv
// Two flip-flop synchroniser for pins from another clock domain.
`timescale 1ns/100ps
module cadsp_sync #(
  parameter int          W          = 1,
  parameter logic [31:0] RESET_VAL  = 32'h0000_0000
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_ff <= RESET_VAL[W-1:0];
      sync_ff <= RESET_VAL[W-1:0];
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign pin_sync = sync_ff;
endmodule : cadsp_sync
